// ===== rtl/fsd_top.v
// flash and ram security gate, backdoor key unlock and flash clock divider registers
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fsd_regs.vh"

// What this block does
// [R1] secured: untrusted writes dropped, reads return zero
// [R2] code in secure memory keeps full access
// [R3] only security pattern 1:0 means unsecured
// [R4] reset copies nonvolatile options into working register
// [R5] debug module enable refused while secured
// [R6] secured: background entry only if pin low
// [R7] backdoor enable zero: no key unlock path
// [R8] key access set: key writes are comparisons
// [R9] software writes key bytes ascending, never adjacent
// [R10] matching key then key access clear unsecures
// [R11] key writes only from secure code
// [R12] protection register writable by debug only
// [R13] passing blank check unsecures until reset
// [R14] loaded flag cleared by reset, set by write
// [R15] divisor bits accept only first write
// [R16] program and erase enabled only once loaded
// [R17] prescale bit selects bus clock divided by eight
// [R18] flash clock is prescaler output over divisor+1
// [R19] software keeps flash clock 150 to 200 kHz
// [R20] timing pulses are whole flash clock cycles
// [R21] flash write before divider load: access error
// [R22] key matches only if all eight in order
module fsd_top (
  input  wire        mclk,
  input  wire        rst,
  input  wire        wb_cyc,
  input  wire        wb_stb,
  input  wire        wb_we,
  input  wire [15:0] wb_adr,
  input  wire [3:0]  wb_sel,
  input  wire [31:0] wb_dat_w,
  output reg  [31:0] wb_dat_r,
  output reg         wb_ack,
  input  wire        src_secure,
  input  wire        src_debug,
  input  wire [7:0]  opt_image,
  input  wire [7:0]  prot_image,
  input  wire [63:0] key_image,
  input  wire        bkgd_pin,
  input  wire        dbg_enable_req,
  input  wire        blank_check_pass,
  output reg         mem_cyc,
  output reg         mem_we,
  output reg  [15:0] mem_adr,
  output reg  [3:0]  mem_sel,
  output reg  [31:0] mem_dat_w,
  input  wire [31:0] mem_dat_r,
  input  wire        mem_ack,
  input  wire        pe_start,
  input  wire [7:0]  pe_pulses,
  output reg         pe_pulse,
  output reg         pe_done,
  output reg         pe_enable,
  output wire        flash_tick,
  output reg         secured,
  output reg         dbg_module_en,
  output reg         bg_entry_ok,
  output reg  [7:0]  prot_working,
  output reg         access_error
);

  localparam ST_IDLE = 3'h1;
  localparam ST_MEM  = 3'h2;
  localparam ST_ACK  = 3'h4;

  reg  [2:0]  state;
  reg  [6:0]  div_reg;
  reg         div_loaded;
  reg  [7:0]  opt_work;
  reg  [2:0]  cfg_hi;
  reg         unsec_latched;
  reg  [3:0]  key_idx;
  reg         key_bad;
  reg         key_unlock;
  reg         bkgd_meta;
  reg         bkgd_sync;
  reg         rst_d;
  reg         boot_bkgd_low;
  reg         pe_busy;
  reg  [7:0]  pe_left;
  reg  [7:0]  rd_byte;

  wire        req;
  wire        in_regs;
  wire        in_flash;
  wire        in_key;
  wire [2:0]  key_sel;
  wire [7:0]  key_byte;
  wire [1:0]  sec_bits;
  wire        is_secured;
  wire        trusted;
  wire        blocked;
  wire        key_acc;
  wire        key_wr;
  wire        byte_wr;
  wire        cfg_wr;
  wire        acc_err_set;
  wire        acc_err_clr;

  assign req      = wb_cyc & wb_stb & state[0];
  assign in_regs  = (wb_adr[15:8] == `FSD_REG_PAGE);
  assign in_flash = wb_adr[`FSD_FLASH_BIT];
  assign in_key   = (wb_adr[15:5] == `FSD_KEY_PAGE);
  assign key_sel  = wb_adr[4:2];
  // key byte k sits in bits 8k+7:8k of the stored image
  assign key_byte = key_image[{key_sel, 3'h0} +: 8];
  assign key_acc  = cfg_hi[`FSD_KEY_WRITE_ACCESS_BIT_BIT-5];
  assign byte_wr  = wb_we & wb_sel[0];

  // an unlock overrides the copied pattern until the next reset
  assign sec_bits   = unsec_latched ? `FSD_SEC_UNSECURE : opt_work[1:0];
  assign is_secured = (sec_bits != `FSD_SEC_UNSECURE); // [R3]

  // the debug controller never counts as secure code, even if it claims to
  assign trusted = src_secure & ~src_debug; // [R2]
  assign blocked = is_secured & ~trusted; // [R1]

  assign key_wr = req & ~in_regs & in_key & key_acc & wb_we; // [R8]
  assign cfg_wr = req & in_regs & byte_wr & (wb_adr[7:0] == `FSD_OFS_CONFIG);

  // a write that the gate drops never flags an error, so untrusted code learns nothing
  assign acc_err_set = req & ~in_regs & ~key_wr & ~blocked & wb_we & in_flash
                     & ~div_loaded; // [R21]
  assign acc_err_clr = req & in_regs & byte_wr & (wb_adr[7:0] == `FSD_OFS_STATUS)
                     & wb_dat_w[`FSD_ACCERR_BIT];

  // register read mux; reserved bits read zero
  always @* begin
    rd_byte = 8'h00;
    case (wb_adr[7:0])
      `FSD_OFS_CLKDIV:  rd_byte = {div_loaded, div_reg}; // [R15]
      `FSD_OFS_OPTIONS: rd_byte = {opt_work[7:6], 4'h0, sec_bits}; // [R3]
      `FSD_OFS_CONFIG:  rd_byte = {cfg_hi, 5'h00};
      `FSD_OFS_PROT:    rd_byte = prot_working;
      `FSD_OFS_STATUS:  rd_byte = {3'h0, access_error, 4'h0};
      default:          rd_byte = 8'h00;
    endcase
  end

  // bus slave: registers and gated accesses answer one cycle after the take,
  // forwarded accesses one cycle after mem_ack
  always @(posedge mclk) begin
    if (rst) begin
      state        <= ST_IDLE;
      wb_ack       <= 1'b0;
      wb_dat_r     <= 32'h0000_0000;
      mem_cyc      <= 1'b0;
      mem_we       <= 1'b0;
      mem_adr      <= 16'h0000;
      mem_sel      <= 4'h0;
      mem_dat_w    <= 32'h0000_0000;
      div_reg      <= `FSD_CLKDIV_RST;
      div_loaded   <= 1'b0; // [R14]
      opt_work     <= opt_image; // [R4]
      prot_working <= prot_image;
      cfg_hi       <= `FSD_CONFIG_RST;
    end else begin
      wb_ack <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req) begin
            if (in_regs) begin
              wb_dat_r <= wb_we ? 32'h0000_0000 : {24'h00_0000, rd_byte};
              if (byte_wr) begin
                case (wb_adr[7:0])
                  `FSD_OFS_CLKDIV: begin
                    if (!div_loaded) begin
                      div_reg    <= wb_dat_w[6:0]; // [R15]
                      div_loaded <= 1'b1; // [R14]
                    end
                  end
                  `FSD_OFS_CONFIG: begin
                    cfg_hi <= wb_dat_w[7:5]; // [R8]
                  end
                  `FSD_OFS_PROT: begin
                    if (src_debug) begin
                      prot_working <= wb_dat_w[7:0]; // [R12]
                    end
                  end
                  default: ;
                endcase
              end
              wb_ack <= 1'b1;
              state  <= ST_ACK;
            end else if (key_wr || blocked || acc_err_set) begin
              // consumed here: compare value, dropped access or refused command
              wb_dat_r <= 32'h0000_0000; // [R1]
              wb_ack   <= 1'b1;
              state    <= ST_ACK;
            end else begin
              mem_cyc   <= 1'b1;
              mem_we    <= wb_we;
              mem_adr   <= wb_adr;
              mem_sel   <= wb_sel;
              mem_dat_w <= wb_dat_w;
              state     <= ST_MEM;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_cyc  <= 1'b0;
            mem_we   <= 1'b0;
            wb_dat_r <= mem_we ? 32'h0000_0000 : mem_dat_r;
            wb_ack   <= 1'b1;
            state    <= ST_ACK;
          end
        end
        // the idle cycle after every answer keeps back-to-back requests apart
        ST_ACK: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // key comparison; a stray order or wrong byte spoils the whole entry
  always @(posedge mclk) begin
    if (rst) begin
      key_idx    <= 4'h0;
      key_bad    <= 1'b0;
      key_unlock <= 1'b0;
    end else begin
      key_unlock <= 1'b0;
      if (cfg_wr) begin
        if (wb_dat_w[`FSD_KEY_WRITE_ACCESS_BIT_BIT] && !key_acc) begin
          key_idx <= 4'h0;
          key_bad <= 1'b0;
        end else if (!wb_dat_w[`FSD_KEY_WRITE_ACCESS_BIT_BIT] && key_acc) begin
          key_unlock <= opt_work[`FSD_BACKDOOR_ENABLE_BIT_BIT] & ~key_bad
                      & (key_idx == `FSD_KEY_BYTES); // [R10] [R7] [R22]
        end
      end else if (key_wr && trusted && opt_work[`FSD_BACKDOOR_ENABLE_BIT_BIT]) begin // [R11] [R7]
        if (key_idx != `FSD_KEY_BYTES && {1'b0, key_sel} == key_idx
            && wb_dat_w[7:0] == key_byte) begin // [R22]
          key_idx <= key_idx + 4'h1;
        end else begin
          key_bad <= 1'b1; // [R22]
        end
      end
    end
  end

  // unlock holds until reset
  always @(posedge mclk) begin
    if (rst) begin
      unsec_latched <= 1'b0;
    end else if (key_unlock || blank_check_pass) begin
      unsec_latched <= 1'b1; // [R10] [R13]
    end
  end

  // a new error in the clearing cycle survives the clear
  always @(posedge mclk) begin
    if (rst) begin
      access_error <= 1'b0;
    end else if (acc_err_set) begin
      access_error <= 1'b1; // [R21]
    end else if (acc_err_clr) begin
      access_error <= 1'b0;
    end
  end

  // pin synchroniser; plain data path so it tracks the pin through reset
  always @(posedge mclk) begin
    bkgd_meta <= bkgd_pin;
    bkgd_sync <= bkgd_meta;
    rst_d     <= rst;
  end

  // the pin level is caught in the first cycle after reset releases
  // limitation: a pin that moves within two cycles of the release may be missed
  always @(posedge mclk) begin
    if (rst) begin
      boot_bkgd_low <= 1'b0;
    end else if (rst_d) begin
      boot_bkgd_low <= ~bkgd_sync; // [R6]
    end
  end

  // status outputs, one cycle behind the internal state
  // trade-off: one cycle of lag buys outputs that come straight from flops
  always @(posedge mclk) begin
    if (rst) begin
      secured       <= 1'b1;
      dbg_module_en <= 1'b0;
      bg_entry_ok   <= 1'b0;
      pe_enable     <= 1'b0;
    end else begin
      secured       <= is_secured; // [R3]
      dbg_module_en <= dbg_enable_req & ~is_secured; // [R5]
      bg_entry_ok   <= ~is_secured | boot_bkgd_low; // [R6]
      pe_enable     <= div_loaded; // [R16]
    end
  end

  fsd_clkdiv u_clkdiv (
    .mclk     (mclk),
    .rst      (rst),
    .run      (div_loaded),
    .prescale (div_reg[`FSD_PRESCALE_BIT]),
    .divisor  (div_reg[`FSD_DIV_MSB:0]),
    .tick     (flash_tick)
  );

  // timing pulse train: starts and ends on flash clock edges, so the sequencer
  // only ever gets whole periods; a start while busy is ignored
  always @(posedge mclk) begin
    if (rst) begin
      pe_busy  <= 1'b0;
      pe_left  <= 8'h00;
      pe_pulse <= 1'b0;
      pe_done  <= 1'b0;
    end else begin
      pe_done <= 1'b0;
      // a zero count would wrap and run a train of 256 periods, so it is refused
      if (pe_start && div_loaded && !pe_busy && pe_pulses != 8'h00) begin // [R16]
        pe_left <= pe_pulses;
        pe_busy <= 1'b1;
      end else if (pe_busy && flash_tick) begin
        if (!pe_pulse) begin
          pe_pulse <= 1'b1; // [R20]
        end else if (pe_left == 8'h01) begin
          pe_pulse <= 1'b0; // [R20]
          pe_busy  <= 1'b0;
          pe_left  <= 8'h00;
          pe_done  <= 1'b1;
        end else begin
          pe_left <= pe_left - 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/fsd_regs.vh
// register map, field positions, reset values and counts of the flash security block
`ifndef FSD_REGS_VH
`define FSD_REGS_VH

// register page: wb_adr[15:8] equal to this selects the local registers
`define FSD_REG_PAGE        8'h00
// byte offsets inside the register page
`define FSD_OFS_CLKDIV      8'h00
`define FSD_OFS_OPTIONS     8'h04
`define FSD_OFS_CONFIG      8'h08
`define FSD_OFS_PROT        8'h0C
`define FSD_OFS_STATUS      8'h10

// wb_adr[15] set marks flash, clear marks ram (outside the register page)
`define FSD_FLASH_BIT       15
// key locations: wb_adr[15:5] equal to this, one word each, index wb_adr[4:2]
`define FSD_KEY_PAGE        11'h7FC
`define FSD_KEY_BYTES       4'h8

// flash_clock_divider fields
`define FSD_DIV_LOADED_BIT  7
`define FSD_PRESCALE_BIT    6
`define FSD_DIV_MSB         5
`define FSD_CLKDIV_RST      7'h00

// options_working_register fields
`define FSD_BACKDOOR_ENABLE_BIT_BIT       7
`define FSD_REDIR_BIT       6
`define FSD_SEC_UNSECURE    2'h2

// flash_config_register fields (bits 7:5 stored, 4:0 read zero)
`define FSD_KEY_WRITE_ACCESS_BIT_BIT      5
`define FSD_CONFIG_RST      3'h0

// status register fields
`define FSD_ACCERR_BIT      4

// prescaler terminal count for divide by eight
`define FSD_PRESCALE_LAST   3'h7

`endif

// ===== rtl/fsd_clkdiv.v
// flash timing clock divider: optional divide by eight, then divide by divisor plus one
`timescale 1ns/10ps
`default_nettype none
`include "fsd_regs.vh"

module fsd_clkdiv (
  input  wire       mclk,
  input  wire       rst,
  input  wire       run,
  input  wire       prescale,
  input  wire [5:0] divisor,
  output reg        tick
);

  reg  [2:0] pre_cnt;
  reg  [5:0] div_cnt;
  wire       pre_tick;

  assign pre_tick = prescale ? (pre_cnt == `FSD_PRESCALE_LAST) : 1'b1; // [R17]

  // held still until the divisor is loaded so the first period is full length
  always @(posedge mclk) begin
    if (rst || !run) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      tick    <= 1'b0;
    end else begin
      tick    <= 1'b0;
      pre_cnt <= pre_cnt + 3'h1;
      if (pre_tick) begin
        if (div_cnt == divisor) begin // [R18]
          div_cnt <= 6'h00;
          tick    <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verif/fsd_mem_model.sv
// memory stand-in that answers forwarded accesses at once or after a wait
`timescale 1ns/10ps
`default_nettype none
module fsd_mem_model (
  input  wire logic        mclk,
  input  wire logic        mem_cyc,
  input  wire logic [15:0] mem_adr,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [31:0]      mem_dat_r
);
  logic [1:0] wait_cnt = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_dat_r = 32'h0;
  // data toggles outside an answer, so a stale value never looks valid
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_dat_r <= ~mem_dat_r;
    if (mem_cyc && !mem_ack) begin
      if (slow && wait_cnt != 2'h3) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        mem_dat_r <= {16'h5a5a, mem_adr};
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/fsd_top_asserts.sv
// port assertions of the flash security block
`timescale 1ns/10ps
`default_nettype none
`include "fsd_regs.vh"
module fsd_top_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [15:0] wb_adr,
  input wire logic [31:0] wb_dat_r,
  input wire logic        wb_ack,
  input wire logic        src_secure,
  input wire logic        src_debug,
  input wire logic        mem_cyc,
  input wire logic        mem_we,
  input wire logic [15:0] mem_adr,
  input wire logic        mem_ack,
  input wire logic        pe_pulse,
  input wire logic        pe_done,
  input wire logic        pe_enable,
  input wire logic        flash_tick,
  input wire logic        secured,
  input wire logic        dbg_module_en,
  input wire logic [7:0]  prot_working
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire untrusted = src_debug || !src_secure;
  wire outside = wb_adr[15:8] != `FSD_REG_PAGE;
  wire prot_wr = wb_stb && wb_we && src_debug && wb_adr == 16'h000c;
  property p_blk;
    $rose(wb_stb) && secured && untrusted && outside |=> wb_ack && !mem_cyc && wb_dat_r == 0;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked access leaked");
  property p_fwd;
    $rose(wb_stb) && !untrusted && outside && wb_adr[15:5] != `FSD_KEY_PAGE
      && !(wb_we && wb_adr[15]) |=> mem_cyc;
  endproperty
  a_fwd: assert property (p_fwd) else $error("trusted access not forwarded");
  property p_ans;
    mem_cyc && mem_ack |=> wb_ack && !mem_cyc;
  endproperty
  a_ans: assert property (p_ans) else $error("memory answer not passed on");
  property p_acc;
    mem_cyc && mem_we && mem_adr[15] |-> pe_enable;
  endproperty
  a_acc: assert property (p_acc) else $error("flash write before divider");
  property p_ld;
    pe_enable |=> pe_enable;
  endproperty
  a_ld: assert property (p_ld) else $error("loaded flag fell");
  property p_pen;
    pe_pulse |-> pe_enable;
  endproperty
  a_pen: assert property (p_pen) else $error("pulse while divider unset");
  property p_pup;
    $rose(pe_pulse) |-> flash_tick || $past(flash_tick);
  endproperty
  a_pup: assert property (p_pup) else $error("pulse start off tick");
  property p_pdn;
    $fell(pe_pulse) |-> pe_done;
  endproperty
  a_pdn: assert property (p_pdn) else $error("pulse end without done");
  property p_dbg;
    secured |-> !dbg_module_en;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug enabled while secured");
  property p_prot;
    !$stable(prot_working) |-> $past(prot_wr);
  endproperty
  a_prot: assert property (p_prot) else $error("protection changed");
endmodule
bind fsd_top fsd_top_asserts fsd_top_asserts_i (.mclk, .rst, .wb_stb, .wb_we, .wb_adr,
  .wb_dat_r, .wb_ack, .src_secure, .src_debug, .mem_cyc, .mem_we, .mem_adr, .mem_ack,
  .pe_pulse, .pe_done, .pe_enable, .flash_tick, .secured, .dbg_module_en, .prot_working);
`default_nettype wire

// ===== verif/testbench.sv
// register-level bench of the flash security block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk, rst, wb_cyc, wb_stb, wb_we, src_secure, src_debug, bkgd_pin;
  logic        dbg_enable_req, blank_check_pass, pe_start, slow;
  logic [15:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, rd;
  logic [7:0]  opt_image, prot_image, pe_pulses;
  logic [63:0] key_image;
  wire  [31:0] wb_dat_r, mem_dat_w, mem_dat_r;
  wire  [15:0] mem_adr;
  wire  [3:0]  mem_sel;
  wire  [7:0]  prot_working;
  wire         wb_ack, mem_cyc, mem_we, mem_ack, pe_pulse, pe_done, pe_enable, flash_tick;
  wire         secured, dbg_module_en, bg_entry_ok, access_error;
  int          error_cnt = 0, samples_checked = 0, cyc_cnt = 0, n, k;
  fsd_top fsd_top_i (.mclk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_dat_r, .wb_ack, .src_secure, .src_debug, .opt_image, .prot_image, .key_image,
    .bkgd_pin, .dbg_enable_req, .blank_check_pass, .mem_cyc, .mem_we, .mem_adr, .mem_sel,
    .mem_dat_w, .mem_dat_r, .mem_ack, .pe_start, .pe_pulses, .pe_pulse, .pe_done,
    .pe_enable, .flash_tick, .secured, .dbg_module_en, .bg_entry_ok, .prot_working,
    .access_error);
  fsd_mem_model fsd_mem_model_i (.mclk, .mem_cyc, .mem_adr, .slow, .mem_ack, .mem_dat_r);
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle; master holds everything until ack is sampled
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic s, g);
    int t;
    @(posedge mclk);
    {wb_cyc, wb_stb, wb_we, src_secure, src_debug} <= {2'h3, w, s, g};
    wb_adr <= a;
    wb_dat_w <= d;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (wb_ack !== 1'b1 && t < 500);
    rd = wb_dat_r;
    {wb_cyc, wb_stb, wb_we} <= 3'h0;
    if (t >= 500) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  task do_reset;
    rst <= 1;
    repeat (20) @(posedge mclk);
    rst <= 0;
    repeat (3) @(posedge mclk);
  endtask
  task key(input logic s, g, input logic [63:0] v);
    wb(1, 16'h0008, 32'h20, 1, 0);
    // gaps come from the idle cycle after each ack
    for (k = 0; k < 8; k++) begin
      wb(1, 16'hff80 + 16'(4 * k), {24'h0, v[8 * k +: 8]}, s, g);
    end
    wb(1, 16'h0008, 32'h0, 1, 0);
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, src_secure, src_debug, bkgd_pin} = 7'h41;
    {dbg_enable_req, blank_check_pass, pe_start, slow} = 4'h8;
    {wb_adr, wb_sel, wb_dat_w, pe_pulses} = {16'h0, 4'hf, 32'h0, 8'h0};
    {opt_image, prot_image, key_image} = {8'h83, 8'hf8, 64'h0123_4567_89ab_cdef};
    do_reset;
    chk("secured", secured, 1);
    wb(0, 16'h0004, 0, 1, 0);
    chk("options", rd, 32'h83);
    chk("dbg_en", dbg_module_en, 0);
    chk("bg_ok", bg_entry_ok, 0);
    wb(0, 16'h0100, 0, 0, 1);
    chk("debug read", rd, 0);
    wb(0, 16'h0100, 0, 0, 0);
    chk("app read", rd, 0);
    slow <= 1;
    wb(0, 16'h0104, 0, 1, 0);
    chk("secure read", rd, 32'h5a5a_0104);
    slow <= 0;
    wb(1, 16'h8000, 32'h11, 1, 0);
    wb(0, 16'h0010, 0, 1, 0);
    chk("acc err", rd & 32'h10, 32'h10);
    chk("pe_en", pe_enable, 0);
    wb(1, 16'h0010, 32'h10, 1, 0);
    chk("acc clr", access_error, 0);
    wb(1, 16'h0000, 32'h5f, 1, 0);
    wb(1, 16'h0000, 32'h01, 1, 0);
    wb(0, 16'h0000, 0, 1, 0);
    chk("divider", rd, 32'hdf);
    chk("pe_en", pe_enable, 1);
    wb(0, 16'h0014, 0, 1, 0);
    wb(1, 16'h8004, 32'h22, 1, 0);
    chk("loaded wr", access_error, 0);
    chk("fwd adr", mem_adr, 32'h8004);
    chk("fwd data", mem_dat_w, 32'h22);
    chk("fwd sel", mem_sel, 32'hf);
    n = 0;
    while (flash_tick !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    n = 1;
    while (flash_tick !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    chk("tick gap", n, 256);
    pe_pulses <= 8'h03;
    pe_start <= 1;
    @(posedge mclk);
    pe_start <= 0;
    n = 0;
    repeat (1200) begin
      @(posedge mclk);
      if (pe_pulse === 1'b1) n++;
    end
    chk("pulse len", n, 768);
    wb(1, 16'h000c, 32'h12, 1, 0);
    wb(0, 16'h000c, 0, 1, 0);
    chk("prot app", rd, 32'hf8);
    wb(1, 16'h000c, 32'h12, 0, 1);
    wb(0, 16'h000c, 0, 0, 1);
    chk("prot dbg", rd, 32'h12);
    key(0, 1, key_image);
    chk("dbg key", secured, 1);
    key(1, 0, key_image ^ 64'h0000_0000_ff00_0000);
    chk("bad key", secured, 1);
    key(1, 0, key_image);
    wb(0, 16'h0004, 0, 1, 0);
    chk("unlocked", rd, 32'h82);
    chk("secured", secured, 0);
    chk("dbg_en", dbg_module_en, 1);
    chk("bg_ok", bg_entry_ok, 1);
    opt_image <= 8'h03;
    bkgd_pin <= 0;
    do_reset;
    chk("bg pin", bg_entry_ok, 1);
    wb(0, 16'h0004, 0, 1, 0);
    chk("options", rd, 32'h03);
    wb(0, 16'h0000, 0, 1, 0);
    chk("div rst", rd, 0);
    key(1, 0, key_image);
    chk("no backdoor", secured, 1);
    blank_check_pass <= 1;
    @(posedge mclk);
    blank_check_pass <= 0;
    repeat (3) @(posedge mclk);
    chk("blank", secured, 0);
    end_of_test;
  end
endmodule
`default_nettype wire
